// >>> common/agu_pkg.sv
// Package: constants and carrier types for the address generator block
package agu_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the Avalon-MM slave)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CIRC_CTRL  = 4'h0;  // Circular control
  localparam logic [3:0] OFS_REV_CTRL   = 4'h4;  // Reverse control
  localparam logic [3:0] OFS_CIRC_START = 4'h8;  // Buffer lower bound
  localparam logic [3:0] OFS_CIRC_END   = 4'hc;  // Buffer upper bound

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CIRC_EN_BIT    = 15;     // Circular enable
  localparam int         PSEL_LSB       = 8;      // Pointer select field
  localparam int         REV_EN_BIT     = 15;     // Reverse enable
  localparam logic [3:0] STACK_PTR      = 4'hf;   // Stack pointer index
  localparam logic [15:0] CIRC_CTRL_RST = 16'h0000;
  localparam logic [15:0] REV_CTRL_RST  = 16'h0000;
  localparam logic [15:0] BOUND_RST     = 16'h0000;
  localparam logic [15:0] STACK_RST     = 16'h0800;  // Stack pointer reset

  // ---------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AGU_MODE_DIRECT,     // Plain register indirect
    AGU_MODE_PRE_INC,
    AGU_MODE_POST_INC,
    AGU_MODE_PRE_DEC,
    AGU_MODE_POST_DEC,
    AGU_MODE_OFFSET      // Register plus offset, no write-back
  } agu_mode_t;

  // Access request from execution unit
  typedef struct packed {
    logic        valid;   // Request present
    logic        write;   // Data write (else read)
    logic        word;    // Word sized (else byte)
    agu_mode_t   mode;
    logic [3:0]  wsel;    // Source working register
    logic [15:0] offset;  // Modifier or offset in bytes
  } agu_req_t;

  // Result toward data memory and register file
  typedef struct packed {
    logic        valid;   // Address valid, one cycle
    logic [15:0] addr;    // Effective address
    logic        wb;      // Write back requested
    logic [3:0]  wsel;    // Register to write back
    logic [15:0] wdata;   // Value to write back
    logic        rev;     // Reversed address in use
    logic        circ;    // Circular wrap applied
  } agu_res_t;

endpackage : agu_pkg

// >>> rtl/agu_bitrev.sv
// Reverse-carry adder for bit-reversed pointer stepping
module agu_bitrev (
  input  wire logic [15:0] ptr,
  input  wire logic [14:0] modifier,
  output logic      [15:0] sum
);

  // ---------------------------------------------------------------
  // Carries run from the top bit downward across bits 15..1
  // ---------------------------------------------------------------
  logic [15:0] mod_b;   // Modifier as byte offset
  logic [16:1] cy;      // Carry chain, cy[16] enters at msb; nothing leaves bit 1

  assign mod_b  = {modifier, 1'b0};  // Word scaled modifier [RULE10]
  assign cy[16] = 1'b0;

  genvar gi;
  generate
    for (gi = 15; gi >= 1; gi--) begin : g_rc
      // Full add, carry passed to next lower bit [RULE16]
      assign sum[gi]  = ptr[gi] ^ mod_b[gi] ^ cy[gi+1];
      assign cy[gi]   = (ptr[gi] & mod_b[gi]) | (cy[gi+1] & (ptr[gi] ^ mod_b[gi]));
    end
  endgenerate

  // Lsb forced clear, words only [RULE13]
  assign sum[0] = 1'b0;

endmodule : agu_bitrev

// >>> rtl/agu_circ.sv
// Circular buffer wrap of a stepped address
module agu_circ (
  input  wire logic [15:0] addr,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  input  wire logic        inc,
  input  wire logic        dec,
  output logic      [15:0] out,
  output logic             wrapped
);

  // ---------------------------------------------------------------
  // Bound compare and wrap
  // ---------------------------------------------------------------
  logic [15:0] len;      // Buffer length in bytes, upper minus lower plus one
  logic        over;     // Past upper bound
  logic        under;    // Past lower bound

  assign len = hi - lo + 16'h0001;
  // Strictly-beyond tests so long jumps still wrap [RULE2]
  assign over  = inc && (addr > hi);
  assign under = dec && (addr < lo);

  always_comb begin
    out     = addr;
    wrapped = 1'b0;
    if (over) begin
      // Keep overshoot distance [RULE17]
      out     = addr - len;
      wrapped = 1'b1;
    end else if (under) begin
      out     = addr + len;
      wrapped = 1'b1;
    end
  end

endmodule : agu_circ

// >>> rtl/agu_modulo_bitrev.sv
// Top: effective address generation with circular and bit-reversed modes
// Notes on behaviour
// RULE1: Circular wrap works with any working register
// RULE2: Wrap at or beyond the active bound; the code wraps only strictly beyond it, not at it
// RULE3: Write back wrapped value for pre/post modify
// RULE4: Offset form wraps address, register untouched
// RULE5: Reversal only on X writes
// RULE6: Only the modifier is bit reversed
// RULE7: Reversal needs select not 15, enable, increment
// RULE8: Software aligns reversed buffer start to size
// RULE9: Fifteen bit reversal modifier held
// RULE10: Modifier scaled to byte addresses, word data
// RULE11: Byte or other modes get normal address
// RULE12: Reversal adds pointer and modifier, ignores offset
// RULE13: Reversal forces address lsb to zero
// RULE14: Reversal beats circular on X writes only
// RULE15: Software avoids read right after control write
// RULE16: Reverse carry addition, msb toward lsb
// RULE17: Wrap keeps overshoot distance
//
// Our own choices: the Avalon-MM register port and the address map.
module agu_modulo_bitrev (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Execution unit
  input  wire agu_pkg::agu_req_t req,
  input  wire logic [15:0]       wreg_value,
  output logic      [3:0]        wreg_rsel,
  output agu_pkg::agu_res_t      res
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] circular_control_reg;  // Enable and pointer selects
  logic [15:0] reverse_control_reg;   // Enable and modifier
  logic [15:0] circ_start;            // Lower bound
  logic [15:0] circ_end;              // Upper bound
  logic        acc_done;              // Second cycle of an access
  logic [31:0] next_rdata;            // Read mux

  logic        reverse_enable;
  logic [14:0] reverse_modifier;
  logic [3:0]  reverse_pointer_select;
  logic        circ_en;
  logic [3:0]  circ_psel;

  assign reverse_enable         = reverse_control_reg[agu_pkg::REV_EN_BIT];
  assign reverse_modifier       = reverse_control_reg[14:0];  // [RULE9]
  assign circ_en                = circular_control_reg[agu_pkg::CIRC_EN_BIT];
  assign reverse_pointer_select = circular_control_reg[agu_pkg::PSEL_LSB +: 4];
  assign circ_psel              = circular_control_reg[3:0];

  // Waitrequest low one cycle after request: fixed 1 wait state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read || avs_write) && !acc_done;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
    end
  end

  // Writes land at the edge where waitrequest is seen low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      circular_control_reg <= agu_pkg::CIRC_CTRL_RST;
      reverse_control_reg  <= agu_pkg::REV_CTRL_RST;
      circ_start           <= agu_pkg::BOUND_RST;
      circ_end             <= agu_pkg::BOUND_RST;
    end else if (avs_write && acc_done) begin
      case (avs_address)
        agu_pkg::OFS_CIRC_CTRL: begin
          if (avs_byteenable[0]) circular_control_reg[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) circular_control_reg[15:8] <= avs_writedata[15:8];
        end
        agu_pkg::OFS_REV_CTRL: begin
          if (avs_byteenable[0]) reverse_control_reg[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) reverse_control_reg[15:8] <= avs_writedata[15:8];
        end
        agu_pkg::OFS_CIRC_START: begin
          if (avs_byteenable[0]) circ_start[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) circ_start[15:8] <= avs_writedata[15:8];
        end
        agu_pkg::OFS_CIRC_END: begin
          if (avs_byteenable[0]) circ_end[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) circ_end[15:8] <= avs_writedata[15:8];
        end
        default: begin
          // Unmapped: write dropped
        end
      endcase
    end
  end

  // Read mux, unmapped reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (avs_address)
      agu_pkg::OFS_CIRC_CTRL:  next_rdata = {16'h0000, circular_control_reg};
      agu_pkg::OFS_REV_CTRL:   next_rdata = {16'h0000, reverse_control_reg};
      agu_pkg::OFS_CIRC_START: next_rdata = {16'h0000, circ_start};
      agu_pkg::OFS_CIRC_END:   next_rdata = {16'h0000, circ_end};
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !acc_done) begin
      avs_readdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Address generation, combinational from request
  // ---------------------------------------------------------------
  logic        is_inc;      // Increment forms
  logic        is_dec;      // Decrement forms
  logic        is_pre;      // Pre modify forms
  logic        modify;      // Any pre or post modify
  logic        rev_active;  // Reversal selected for this access
  logic        circ_sel;    // Circular applies to this access
  logic [15:0] stepped;     // Pointer plus step or offset
  logic [15:0] rev_sum;     // Reverse carry result
  logic [15:0] circ_out;
  logic        circ_wrap;
  logic [15:0] next_addr;
  logic [15:0] next_wb;
  logic        next_rev;

  assign wreg_rsel = req.wsel;   // Register file read select

  assign is_inc = (req.mode == agu_pkg::AGU_MODE_PRE_INC) || (req.mode == agu_pkg::AGU_MODE_POST_INC);
  assign is_dec = (req.mode == agu_pkg::AGU_MODE_PRE_DEC) || (req.mode == agu_pkg::AGU_MODE_POST_DEC);
  assign is_pre = (req.mode == agu_pkg::AGU_MODE_PRE_INC) || (req.mode == agu_pkg::AGU_MODE_PRE_DEC);
  assign modify = is_inc || is_dec;

  // Needs select not stack, enable, inc form, word write [RULE7] [RULE5] [RULE11]
  assign rev_active = reverse_enable && (reverse_pointer_select != agu_pkg::STACK_PTR)
                      && (req.wsel == reverse_pointer_select) && is_inc && req.write && req.word;

  // Any working register may be the circular pointer [RULE1]
  // Reversal disables circular on writes only; reads keep it [RULE14]
  assign circ_sel = circ_en && (req.wsel == circ_psel) && !rev_active;

  always_comb begin
    stepped = wreg_value;
    case (req.mode)
      agu_pkg::AGU_MODE_PRE_INC, agu_pkg::AGU_MODE_POST_INC: stepped = wreg_value + req.offset;
      agu_pkg::AGU_MODE_PRE_DEC, agu_pkg::AGU_MODE_POST_DEC: stepped = wreg_value - req.offset;
      agu_pkg::AGU_MODE_OFFSET:                              stepped = wreg_value + req.offset;
      default:                                               stepped = wreg_value;
    endcase
  end

  // Pointer plus modifier, offset ignored; pointer order normal [RULE12] [RULE6]
  agu_bitrev u_bitrev (
    .ptr      (wreg_value),
    .modifier (reverse_modifier),
    .sum      (rev_sum)
  );

  // Offset form counts as incrementing for the bound test
  agu_circ u_circ (
    .addr    (stepped),
    .lo      (circ_start),
    .hi      (circ_end),
    .inc     (circ_sel && (is_inc || req.mode == agu_pkg::AGU_MODE_OFFSET)),
    .dec     (circ_sel && is_dec),
    .out     (circ_out),
    .wrapped (circ_wrap)
  );

  always_comb begin
    next_rev  = rev_active;
    next_wb   = circ_out;
    next_addr = wreg_value;
    if (rev_active) begin
      // Post form uses old pointer, pre form the reversed sum [RULE13]
      next_wb   = rev_sum;
      next_addr = is_pre ? rev_sum : {wreg_value[15:1], 1'b0};
    end else if (req.mode == agu_pkg::AGU_MODE_OFFSET) begin
      next_addr = circ_out;  // Wrapped address only [RULE4]
    end else if (is_pre) begin
      next_addr = circ_out;
    end else begin
      next_addr = wreg_value;
    end
  end

  // Registered result toward memory bus and register file
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res <= '0;
    end else begin
      res.valid <= req.valid;
      res.addr  <= next_addr;
      res.wb    <= req.valid && modify;  // Write back for modify forms [RULE3]
      res.wsel  <= req.wsel;
      res.wdata <= next_wb;
      res.rev   <= req.valid && next_rev;
      res.circ  <= req.valid && circ_wrap && !next_rev;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_rev_lsb_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE13]
    res.rev |-> (res.addr[0] == 1'b0)) else $error("reversed address lsb set");
  a_rev_write_only: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE5]
    (req.valid && !req.write) |=> !res.rev) else $error("reversal on read");
  a_rev_no_stack: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE7]
    (req.valid && req.wsel == agu_pkg::STACK_PTR) |=> !res.rev) else $error("reversal on stack");
  a_rev_byte_none: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE11]
    (req.valid && !req.word) |=> !res.rev) else $error("reversal on byte");
  a_offset_no_wb: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE4]
    (req.valid && req.mode == agu_pkg::AGU_MODE_OFFSET) |=> !res.wb) else $error("offset wrote back");
  a_modify_wb: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE3]
    (req.valid && (is_inc || is_dec)) |=> res.wb) else $error("modify missing write back");
  a_circ_in_range: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE2]
    (req.valid && circ_sel && is_inc && stepped > circ_end && stepped - circ_end <= circ_end - circ_start)
    |=> (res.wdata <= circ_end && res.wdata >= circ_start)) else $error("wrap out of range");
  a_rev_excl_circ: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE14]
    res.rev |-> !res.circ) else $error("circular with reversal");
  a_rev_sum: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE12]
    (req.valid && rev_active) |=> (res.wdata == $past(rev_sum))) else $error("reversed sum wrong");

endmodule : agu_modulo_bitrev

// >>> verif/agu_exec_model.sv
// Execution unit model: working register file facing the address generator
module agu_exec_model (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [3:0]        wreg_rsel,
  input  wire agu_pkg::agu_res_t res,
  input  wire logic              ld_en,
  input  wire logic [3:0]        ld_sel,
  input  wire logic [15:0]       ld_val,
  output logic      [15:0]       wreg_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wreg [16];  // Working registers
  // ------------------------------------------------------------
  // Preload from the bench wins over write-back
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) wreg[i] <= (i == 15) ? agu_pkg::STACK_RST : 16'h0000;
    end else if (ld_en) begin
      wreg[ld_sel] <= ld_val;
    end else if (res.valid && res.wb) begin
      wreg[res.wsel] <= res.wdata;
    end
  end
  // Same-cycle read, as the design expects
  assign wreg_value = wreg[wreg_rsel];
endmodule : agu_exec_model

// >>> verif/tb.sv
// Testbench: register bus, circular and reversed stepping against a model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              rstn    = 1'b0;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  agu_pkg::agu_req_t req = '0;
  agu_pkg::agu_res_t res;
  logic [15:0]       wreg_value, ld_val = 16'h0;
  logic [3:0]        wreg_rsel, ld_sel = 4'h0;
  logic              ld_en = 1'b0;
  int                num_errors = 0, samples_checked = 0;
  logic [15:0]       wm [16];  // Mirror of working registers
  logic              cen, ren;  // Mirror of enables
  logic [3:0]        csel, psel;
  logic [15:0]       lo, hi;
  logic [14:0]       rmod;
  logic [3:0]        be = 4'h3;  // Byte lanes of the next bus access
  logic [3:0]        rd_ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};  // Reset read places
  logic [3:0]        cptr [3] = '{4'h0, 4'h7, 4'he};  // Circular pointers tried

  agu_modulo_bitrev dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req(req),
    .wreg_value(wreg_value), .wreg_rsel(wreg_rsel), .res(res));
  agu_exec_model exu (.clk_sys(clk_sys), .rstn(rstn), .wreg_rsel(wreg_rsel), .res(res),
    .ld_en(ld_en), .ld_sel(ld_sel), .ld_val(ld_val), .wreg_value(wreg_value));

  always #2.5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(string name, logic [39:0] seen, logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Bus access: hold until waitrequest is seen low, bounded wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'($urandom), d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // A stuck slave ends the run through the verdict
    if (n >= 20) begin
      chk("bus_wait", 40'h1, 40'h0);
      give_verdict();
    end
  endtask : bus
  task automatic rd_chk(logic [3:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    chk("readdata", {8'h0, q}, {8'h0, e});
  endtask : rd_chk
  // Program both control registers and the bounds
  task automatic setc(logic ce, logic [3:0] cs, logic [3:0] ps, logic re, logic [14:0] m);
    logic [31:0] q;
    cen = ce; csel = cs; psel = ps; ren = re; rmod = m;
    bus(1'b1, agu_pkg::OFS_CIRC_CTRL, {ce, 3'h0, ps, 4'h0, cs}, q);
    bus(1'b1, agu_pkg::OFS_REV_CTRL, {re, m}, q);
    bus(1'b1, agu_pkg::OFS_CIRC_START, lo, q);
    bus(1'b1, agu_pkg::OFS_CIRC_END, hi, q);
  endtask : setc
  task automatic ld(logic [3:0] s, logic [15:0] v);
    @(posedge clk_sys);
    ld_en <= 1'b1;
    ld_sel <= s;
    ld_val <= v;
    @(posedge clk_sys);
    ld_en <= 1'b0;
    wm[s] = v;
  endtask : ld
  // Reverse-carry add: carries run from msb toward lsb
  function automatic logic [15:0] rc_add(logic [15:0] a, logic [15:0] b);
    logic [15:0] ra, rb, s, r;
    for (int i = 0; i < 16; i++) begin
      ra[i] = a[15-i];
      rb[i] = b[15-i];
    end
    s = ra + rb;
    for (int i = 0; i < 16; i++) r[i] = s[15-i];
    return r;
  endfunction : rc_add

  // ------------------------------------------------------------
  // One address request, predicted and compared a cycle later
  // ------------------------------------------------------------
  task automatic op(logic wr, logic wd, agu_pkg::agu_mode_t m, logic [3:0] ws, logic [15:0] ofs);
    agu_pkg::agu_res_t e, r;
    logic [15:0] w, s;
    logic pre, inc, dec, rv, cw;
    w = wm[ws];
    pre = m inside {agu_pkg::AGU_MODE_PRE_INC, agu_pkg::AGU_MODE_PRE_DEC};
    inc = m inside {agu_pkg::AGU_MODE_PRE_INC, agu_pkg::AGU_MODE_POST_INC, agu_pkg::AGU_MODE_OFFSET};
    dec = m inside {agu_pkg::AGU_MODE_PRE_DEC, agu_pkg::AGU_MODE_POST_DEC};
    rv = ren && psel != 4'hf && ws == psel && wr && wd &&
         m inside {agu_pkg::AGU_MODE_PRE_INC, agu_pkg::AGU_MODE_POST_INC};
    s = rv ? rc_add(w, {rmod, 1'b0}) & 16'hfffe : inc ? w + ofs : dec ? w - ofs : w;
    cw = cen && ws == csel && !rv && ((inc && s > hi) || (dec && s < lo));
    if (cw) s = inc ? s - (hi - lo + 16'h1) : s + (hi - lo + 16'h1);
    e = '0;
    e.valid = 1'b1;
    e.wb = (inc || dec) && m != agu_pkg::AGU_MODE_OFFSET;
    e.wsel = ws;
    e.wdata = s;
    e.rev = rv;
    e.circ = cw;
    e.addr = (pre || m == agu_pkg::AGU_MODE_OFFSET) ? s : rv ? w & 16'hfffe : w;
    @(posedge clk_sys);
    req <= '{valid: 1'b1, write: wr, word: wd, mode: m, wsel: ws, offset: ofs};
    @(posedge clk_sys);
    req <= agu_pkg::agu_req_t'({1'b0, 25'($urandom)});
    #1;
    r = res;
    if (!e.wb) begin
      r.wdata = '0;
      e.wdata = '0;
    end
    chk("res", r, e);
    if (e.wb) wm[ws] = s;
  endtask : op

  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    chk("watchdog", 40'h1, 40'h0);
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    void'($urandom(32'h9a012430));
    foreach (wm[i]) wm[i] = (i == 15) ? agu_pkg::STACK_RST : 16'h0;
    lo = 16'h1000;
    hi = 16'h101f;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset values, then an unmapped place
    foreach (rd_ofs[i]) rd_chk(rd_ofs[i], 32'h0);
    bus(1'b1, agu_pkg::OFS_REV_CTRL, 16'h7fff, q);
    rd_chk(agu_pkg::OFS_REV_CTRL, 32'h7fff);
    // Single byte lanes land alone
    be = 4'h2;
    bus(1'b1, agu_pkg::OFS_CIRC_START, 16'h1234, q);
    rd_chk(agu_pkg::OFS_CIRC_START, 32'h1200);
    be = 4'h1;
    bus(1'b1, agu_pkg::OFS_CIRC_START, 16'h5678, q);
    rd_chk(agu_pkg::OFS_CIRC_START, 32'h1278);
    be = 4'h3;
    // Circular wrap on several registers, bounds overshot both ways
    foreach (cptr[i]) begin
      setc(1'b1, cptr[i], 4'hf, 1'b0, 15'h0);
      ld(csel, 16'h101e);
      op(1, 1, agu_pkg::AGU_MODE_POST_INC, csel, 16'h2);
      ld(csel, 16'h101c);
      op(1, 1, agu_pkg::AGU_MODE_PRE_INC, csel, 16'h8);
      op(0, 1, agu_pkg::AGU_MODE_POST_DEC, csel, 16'h6);
      op(0, 1, agu_pkg::AGU_MODE_PRE_DEC, csel, 16'h40);
      op(1, 0, agu_pkg::AGU_MODE_OFFSET, csel, 16'h1e);
      op(0, 1, agu_pkg::AGU_MODE_DIRECT, csel, 16'h2);
    end
    // Reversed stepping over an aligned buffer, step of half its size
    ld(4'h5, 16'h2000);
    setc(1'b0, 4'h0, 4'h5, 1'b1, 15'h8);
    repeat (9) op(1, 1, agu_pkg::AGU_MODE_POST_INC, 4'h5, 16'($urandom_range(64)));
    op(1, 1, agu_pkg::AGU_MODE_PRE_INC, 4'h5, 16'h2);
    op(0, 1, agu_pkg::AGU_MODE_POST_INC, 4'h5, 16'h2);
    op(1, 0, agu_pkg::AGU_MODE_POST_INC, 4'h5, 16'h1);
    op(1, 1, agu_pkg::AGU_MODE_POST_DEC, 4'h5, 16'h2);
    op(1, 1, agu_pkg::AGU_MODE_OFFSET, 4'h5, 16'h4);
    setc(1'b0, 4'h0, 4'hf, 1'b1, 15'h8);
    op(1, 1, agu_pkg::AGU_MODE_POST_INC, 4'hf, 16'h2);
    // Both modes on one pointer
    setc(1'b1, 4'h5, 4'h5, 1'b1, 15'h4);
    ld(4'h5, 16'h101b);
    op(1, 1, agu_pkg::AGU_MODE_POST_INC, 4'h5, 16'h2);
    op(0, 1, agu_pkg::AGU_MODE_POST_INC, 4'h5, 16'h20);
    // Random traffic under random settings
    repeat (4) begin
      setc(1'($urandom), 4'($urandom), 4'($urandom), 1'($urandom), 15'($urandom));
      repeat (80) op(1'($urandom), 1'($urandom), agu_pkg::agu_mode_t'(3'($urandom_range(5))),
                     4'($urandom), 16'($urandom_range(64)));
    end
    give_verdict();
  end
endmodule : tb
